// file: adc_stats_pkg.sv
// Shared constants, field layouts and carrier types for the result checker
package adc_stats_pkg;
    // Widths
    localparam int DATA_W = 16;
    localparam int ADDR_W = 16;
    localparam int BUS_W = 32;
    localparam int CNT_W = 8;
    localparam int SUM_W = 23;
    localparam int SQ_W = 39;
    localparam int WIDE_W = 46;
    localparam int VAR_W = 31;
    // Register byte addresses
    localparam logic [15:0] ADDR_UPPER_THR = 16'h20b0;
    localparam logic [15:0] ADDR_UPPER_HYST = 16'h20b4;
    localparam logic [15:0] ADDR_DELTA = 16'h20b8;
    localparam logic [15:0] ADDR_VAR = 16'h21c0;
    localparam logic [15:0] ADDR_CTRL = 16'h21c4;
    localparam logic [15:0] ADDR_MEAN = 16'h21c8;
    localparam logic [15:0] ADDR_FLAGS = 16'h21d0;
    // Statistics control field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SEL_LSB = 4;
    localparam int CTRL_SEL_MSB = 6;
    localparam int CTRL_USED_MSB = 11;
    // Flag bit positions
    localparam int FLAG_UPPER_BIT = 0;
    localparam int FLAG_DELTA_BIT = 1;
    // Reset values
    localparam logic [15:0] RST_16 = 16'h0000;
    localparam logic [31:0] RST_32 = 32'h0000_0000;
    localparam logic [11:0] RST_CTRL = 12'h000;
    // Block length codes and their log2 lengths
    localparam logic [2:0] SEL_128 = 3'h0;
    localparam logic [2:0] SEL_64 = 3'h1;
    localparam logic [2:0] SEL_32 = 3'h2;
    localparam logic [2:0] SEL_16 = 3'h3;
    localparam logic [2:0] SEL_8 = 3'h4;
    localparam logic [2:0] LOG_128 = 3'h7;
    localparam logic [2:0] LOG_64 = 3'h6;
    localparam logic [2:0] LOG_32 = 3'h5;
    localparam logic [2:0] LOG_16 = 3'h4;
    localparam logic [2:0] LOG_8 = 3'h3;

    // One conversion result with its strobe
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } sample_t;

    // One register bus request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    // Log2 of the block length; undefined codes fall to the shortest block
    function automatic logic [2:0] block_log2(input logic [2:0] sel);
        case (sel)
            SEL_128: block_log2 = LOG_128;
            SEL_64: block_log2 = LOG_64;
            SEL_32: block_log2 = LOG_32;
            SEL_16: block_log2 = LOG_16;
            SEL_8: block_log2 = LOG_8;
            default: block_log2 = LOG_8;
        endcase
    endfunction
endpackage

// file: limit_check.sv
// Upper threshold with hysteresis and consecutive-result delta checks
module limit_check (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire adc_stats_pkg::sample_t sample,
    input wire logic [15:0] upper_threshold,
    input wire logic [15:0] upper_hysteresis_value,
    input wire logic [15:0] delta_limit_value,
    input wire logic clr_upper,
    input wire logic clr_delta,
    output logic upper_limit_flag,
    output logic delta_error_flag
);
    logic [15:0] prev_r; // Last accepted result
    logic prev_seen_r; // A previous result exists
    logic [16:0] release_sum; // Result plus hysteresis, no wrap
    logic [15:0] abs_diff; // Distance to previous result

    // Release test in 17 bits so a large hysteresis cannot wrap
    assign release_sum = {1'b0, sample.data} + {1'b0, upper_hysteresis_value};
    assign abs_diff = (sample.data > prev_r) ? sample.data - prev_r : prev_r - sample.data;

    // Upper flag: set wins, hysteresis release, then software clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            upper_limit_flag <= 1'b0;
        end else if (sample.valid && sample.data > upper_threshold) begin
            upper_limit_flag <= 1'b1;
        end else if (sample.valid && release_sum < {1'b0, upper_threshold}) begin
            upper_limit_flag <= 1'b0;
        end else if (clr_upper) begin
            upper_limit_flag <= 1'b0;
        end
    end

    // Previous result, needed before any delta can be judged
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            prev_r <= adc_stats_pkg::RST_16;
            prev_seen_r <= 1'b0;
        end else if (sample.valid) begin
            prev_r <= sample.data;
            prev_seen_r <= 1'b1;
        end
    end

    // Delta flag is sticky until software clears it; set wins
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            delta_error_flag <= 1'b0;
        end else if (sample.valid && prev_seen_r && abs_diff > delta_limit_value) begin
            delta_error_flag <= 1'b1;
        end else if (clr_delta) begin
            delta_error_flag <= 1'b0;
        end
    end
endmodule

// file: stats_engine.sv
// Block mean and population variance over a selectable number of results
module stats_engine (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire adc_stats_pkg::sample_t sample,
    input wire logic stats_enable,
    input wire logic [2:0] sample_count_sel,
    output logic [15:0] mean_q,
    output logic [30:0] var_q,
    output logic block_done,
    output logic [7:0] sample_idx
);
    logic [22:0] sum_r; // Running sum
    logic [38:0] sq_r; // Running sum of squares
    logic [22:0] sum_nxt;
    logic [38:0] sq_nxt;
    logic [2:0] k; // Log2 of block length
    logic [7:0] last_idx; // Index of final sample in block
    logic last;
    logic [45:0] spread; // N*sum(x^2) - sum(x)^2

    assign k = adc_stats_pkg::block_log2(sample_count_sel);
    assign last_idx = 8'((9'h001 << k) - 9'h001);
    assign last = sample.valid && sample_idx >= last_idx;
    assign sum_nxt = sum_r + 23'(sample.data);
    // Operands widened first so the square is never cut to 16 bits
    assign sq_nxt = sq_r + 39'(sample.data) * 39'(sample.data);
    // Single division by N*N keeps the rounding to one step
    assign spread = (46'(sq_nxt) << k) - (46'(sum_nxt) * 46'(sum_nxt));

    // Accumulators restart after each block and while disabled
    always_ff @(posedge core_clk) begin
        if (!rst_b || !stats_enable) begin
            sum_r <= '0;
            sq_r <= '0;
            sample_idx <= '0;
        end else if (last) begin
            sum_r <= '0;
            sq_r <= '0;
            sample_idx <= '0;
        end else if (sample.valid) begin
            sum_r <= sum_nxt;
            sq_r <= sq_nxt;
            sample_idx <= sample_idx + 8'h01;
        end
    end

    // Results move only at a block end; disabled keeps them
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            mean_q <= adc_stats_pkg::RST_16;
            var_q <= '0;
            block_done <= 1'b0;
        end else begin
            block_done <= stats_enable && last;
            if (stats_enable && last) begin
                mean_q <= 16'(sum_nxt >> k);
                var_q <= 31'(spread >> {k, 1'b0});
            end
        end
    end
endmodule

// file: adc_result_check_and_stats.sv
// Result checker and statistics block with its register port
module adc_result_check_and_stats (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire adc_stats_pkg::sample_t sample_in,
    input wire adc_stats_pkg::bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    output logic upper_limit_flag,
    output logic delta_error_flag
);
    // Software registers
    logic [15:0] upper_threshold_r; // Upper compare level
    logic [15:0] upper_hysteresis_r; // Release margin
    logic [15:0] delta_limit_r; // Allowed step
    logic [11:0] stats_control_r; // Enable, reserved, count, deviation
    logic [31:0] rdata_r; // Read data register
    // Decoded strobes and control fields
    logic clr_upper;
    logic clr_delta;
    logic stats_enable;
    logic [2:0] sample_count_sel;
    logic [4:0] deviation_config; // Stored only, no logic behind it
    // Statistics results
    logic [15:0] mean_q;
    logic [30:0] var_q;
    logic block_done;
    logic [7:0] sample_idx;

    // Control fields
    assign stats_enable = stats_control_r[adc_stats_pkg::CTRL_EN_BIT];
    assign sample_count_sel =
        stats_control_r[adc_stats_pkg::CTRL_SEL_MSB:adc_stats_pkg::CTRL_SEL_LSB];
    assign deviation_config =
        stats_control_r[adc_stats_pkg::CTRL_USED_MSB:adc_stats_pkg::CTRL_SEL_MSB + 1];

    // Write strobe aimed at one register address
    function automatic logic wr_hit(input adc_stats_pkg::bus_req_t req, input logic [15:0] a);
        wr_hit = req.wr && req.addr == a;
    endfunction

    // Write-one-to-clear on the flag register
    assign clr_upper = wr_hit(bus_req, adc_stats_pkg::ADDR_FLAGS)
        && bus_req.wdata[adc_stats_pkg::FLAG_UPPER_BIT];
    assign clr_delta = wr_hit(bus_req, adc_stats_pkg::ADDR_FLAGS)
        && bus_req.wdata[adc_stats_pkg::FLAG_DELTA_BIT];

    // Threshold register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            upper_threshold_r <= adc_stats_pkg::RST_16;
        end else if (wr_hit(bus_req, adc_stats_pkg::ADDR_UPPER_THR)) begin
            upper_threshold_r <= bus_req.wdata[15:0];
        end
    end

    // Hysteresis register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            upper_hysteresis_r <= adc_stats_pkg::RST_16;
        end else if (wr_hit(bus_req, adc_stats_pkg::ADDR_UPPER_HYST)) begin
            upper_hysteresis_r <= bus_req.wdata[15:0];
        end
    end

    // Delta limit register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            delta_limit_r <= adc_stats_pkg::RST_16;
        end else if (wr_hit(bus_req, adc_stats_pkg::ADDR_DELTA)) begin
            delta_limit_r <= bus_req.wdata[15:0];
        end
    end

    // Statistics control; reserved bits 3:1 are kept as written
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            stats_control_r <= adc_stats_pkg::RST_CTRL;
        end else if (wr_hit(bus_req, adc_stats_pkg::ADDR_CTRL)) begin
            stats_control_r <= bus_req.wdata[11:0];
        end
    end

    // Read mux; data stand one cycle, zero otherwise and when unmapped
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_r <= adc_stats_pkg::RST_32;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                adc_stats_pkg::ADDR_UPPER_THR: rdata_r <= {16'h0000, upper_threshold_r};
                adc_stats_pkg::ADDR_UPPER_HYST: rdata_r <= {16'h0000, upper_hysteresis_r};
                adc_stats_pkg::ADDR_DELTA: rdata_r <= {16'h0000, delta_limit_r};
                adc_stats_pkg::ADDR_VAR: rdata_r <= {1'b0, var_q};
                adc_stats_pkg::ADDR_CTRL: rdata_r <= {20'h0_0000, stats_control_r};
                adc_stats_pkg::ADDR_MEAN: rdata_r <= {16'h0000, mean_q};
                adc_stats_pkg::ADDR_FLAGS: rdata_r <= {30'h0000_0000,
                    delta_error_flag, upper_limit_flag};
                default: rdata_r <= adc_stats_pkg::RST_32;
            endcase
        end else begin
            rdata_r <= adc_stats_pkg::RST_32;
        end
    end

    assign bus_rdata = rdata_r;

    // Threshold, hysteresis and delta checks
    limit_check u_limit (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sample(sample_in),
        .upper_threshold(upper_threshold_r),
        .upper_hysteresis_value(upper_hysteresis_r),
        .delta_limit_value(delta_limit_r),
        .clr_upper(clr_upper),
        .clr_delta(clr_delta),
        .upper_limit_flag(upper_limit_flag),
        .delta_error_flag(delta_error_flag)
    );

    // Mean and variance per block
    stats_engine u_stats (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sample(sample_in),
        .stats_enable(stats_enable),
        .sample_count_sel(sample_count_sel),
        .mean_q(mean_q),
        .var_q(var_q),
        .block_done(block_done),
        .sample_idx(sample_idx)
    );

    // Checking helpers: previous result as the checker sees it
    logic [15:0] chk_prev_r;
    logic chk_seen_r;
    logic [16:0] chk_rel;
    logic [15:0] chk_diff;
    logic [7:0] chk_last;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            chk_prev_r <= adc_stats_pkg::RST_16;
            chk_seen_r <= 1'b0;
        end else if (sample_in.valid) begin
            chk_prev_r <= sample_in.data;
            chk_seen_r <= 1'b1;
        end
    end

    assign chk_rel = {1'b0, sample_in.data} + {1'b0, upper_hysteresis_r};
    assign chk_diff = (sample_in.data > chk_prev_r) ?
        sample_in.data - chk_prev_r : chk_prev_r - sample_in.data;
    assign chk_last = 8'((9'h001 << adc_stats_pkg::block_log2(sample_count_sel)) - 9'h001);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // Result above threshold raises the flag next cycle
    property p_upper_set;
        sample_in.valid && sample_in.data > upper_threshold_r |=> upper_limit_flag;
    endproperty
    a_upper_set: assert property (p_upper_set) else $error("upper flag not set");

    // Flag holds while no release result and no clear arrive
    property p_upper_hold;
        upper_limit_flag && !(sample_in.valid && chk_rel < {1'b0, upper_threshold_r})
            && !clr_upper |=> upper_limit_flag;
    endproperty
    a_upper_hold: assert property (p_upper_hold) else $error("upper flag dropped");

    // Result below the release level drops the flag
    property p_upper_release;
        sample_in.valid && chk_rel < {1'b0, upper_threshold_r} |=> !upper_limit_flag;
    endproperty
    a_upper_release: assert property (p_upper_release)
        else $error("upper flag not released");

    // Large step raises delta flag and it stays without a clear
    property p_delta_set;
        sample_in.valid && chk_seen_r && chk_diff > delta_limit_r
            ##1 !clr_delta |=> delta_error_flag;
    endproperty
    a_delta_set: assert property (p_delta_set) else $error("delta flag not set");

    // Block ends on the last result of the selected length; a length change mid-block is legal
    property p_count_range;
        sample_in.valid && stats_enable && sample_idx >= chk_last
            |=> sample_idx == 8'h00 && block_done;
    endproperty
    a_count_range: assert property (p_count_range) else $error("block index overrun");

    // Disabled statistics leave mean and variance untouched
    property p_stats_hold;
        !stats_enable |=> $stable(mean_q) && $stable(var_q) && !block_done;
    endproperty
    a_stats_hold: assert property (p_stats_hold) else $error("stats moved while off");

    // Mean read returns the mean, upper half zero
    property p_mean_read;
        bus_req.rd && bus_req.addr == adc_stats_pkg::ADDR_MEAN
            |=> bus_rdata == {16'h0000, $past(mean_q)};
    endproperty
    a_mean_read: assert property (p_mean_read) else $error("mean read wrong");

    // Variance read keeps bit 31 clear
    property p_var_read;
        bus_req.rd && bus_req.addr == adc_stats_pkg::ADDR_VAR
            |=> bus_rdata == {1'b0, $past(var_q)};
    endproperty
    a_var_read: assert property (p_var_read) else $error("variance read wrong");

    // Threshold write lands in its register
    property p_thr_write;
        bus_req.wr && bus_req.addr == adc_stats_pkg::ADDR_UPPER_THR
            |=> upper_threshold_r == $past(bus_req.wdata[15:0]);
    endproperty
    a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

    // Mean and variance change only when a block completes
    property p_block_update;
        !block_done |-> $stable(mean_q) && $stable(var_q);
    endproperty
    a_block_update: assert property (p_block_update) else $error("stats moved mid-block");

    // No result above the threshold keeps a clear flag clear
    property p_upper_quiet;
        !upper_limit_flag && !(sample_in.valid && sample_in.data > upper_threshold_r)
            |=> !upper_limit_flag;
    endproperty
    a_upper_quiet: assert property (p_upper_quiet) else $error("upper flag spurious");

    // Software clear works unless a new crossing arrives with it
    property p_upper_clear;
        clr_upper && !(sample_in.valid && sample_in.data > upper_threshold_r)
            |=> !upper_limit_flag;
    endproperty
    a_upper_clear: assert property (p_upper_clear) else $error("upper clear lost");

    // No large step keeps a clear delta flag clear
    property p_delta_quiet;
        !delta_error_flag && !(sample_in.valid && chk_seen_r && chk_diff > delta_limit_r)
            |=> !delta_error_flag;
    endproperty
    a_delta_quiet: assert property (p_delta_quiet) else $error("delta flag spurious");

    // Delta clear works unless a new large step arrives with it
    property p_delta_clear;
        clr_delta && !(sample_in.valid && chk_seen_r && chk_diff > delta_limit_r)
            |=> !delta_error_flag;
    endproperty
    a_delta_clear: assert property (p_delta_clear) else $error("delta clear lost");

    // Hysteresis write lands
    property p_hyst_write;
        bus_req.wr && bus_req.addr == adc_stats_pkg::ADDR_UPPER_HYST
            |=> upper_hysteresis_r == $past(bus_req.wdata[15:0]);
    endproperty
    a_hyst_write: assert property (p_hyst_write) else $error("hysteresis write lost");

    // Delta limit write lands
    property p_delta_write;
        bus_req.wr && bus_req.addr == adc_stats_pkg::ADDR_DELTA
            |=> delta_limit_r == $past(bus_req.wdata[15:0]);
    endproperty
    a_delta_write: assert property (p_delta_write) else $error("delta limit write lost");

    // Control write keeps the twelve stored bits
    property p_ctrl_write;
        bus_req.wr && bus_req.addr == adc_stats_pkg::ADDR_CTRL
            |=> stats_control_r == $past(bus_req.wdata[adc_stats_pkg::CTRL_USED_MSB:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    // Flag read shows both flags in the two low bits
    property p_flags_read;
        bus_req.rd && bus_req.addr == adc_stats_pkg::ADDR_FLAGS
            |=> bus_rdata == {30'h0000_0000, $past(delta_error_flag),
            $past(upper_limit_flag)};
    endproperty
    a_flags_read: assert property (p_flags_read) else $error("flag read wrong");

    // Read data fall to zero so a stale word is never taken as fresh
    property p_rdata_idle;
        !bus_req.rd |=> bus_rdata == adc_stats_pkg::RST_32;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data lingered");

    // Main scenarios
    c_upper: cover property (sample_in.valid && sample_in.data > upper_threshold_r);
    c_delta: cover property ($rose(delta_error_flag));
    c_block: cover property (block_done && sample_count_sel == adc_stats_pkg::SEL_8);
    c_release: cover property ($fell(upper_limit_flag) && !$past(clr_upper));
    c_devcfg: cover property (deviation_config != 5'h00);
endmodule

// file: adc_result_src.sv
// Behavioural source of conversion results for the result checker
module adc_result_src (
    input wire logic core_clk,
    output adc_stats_pkg::sample_t sample_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle at time zero, strobe low
    initial begin
        sample_out <= '{valid: 1'b0, data: 16'hffff};
    end

    // One result, valid for exactly one cycle, then gap idle cycles
    // Idle data is the inverse of the result so stale values are never trusted
    task automatic send(input logic [15:0] d, input int gap);
        @(posedge core_clk);
        sample_out <= '{valid: 1'b1, data: d};
        @(posedge core_clk);
        sample_out <= '{valid: 1'b0, data: ~d};
        repeat (gap) @(posedge core_clk);
    endtask
endmodule

// file: adc_result_check_and_stats_tb.sv
// Self-checking bench for the result checker and statistics block
module adc_result_check_and_stats_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk;
    logic rst_b;
    adc_stats_pkg::sample_t sample_in;
    adc_stats_pkg::bus_req_t bus_req;
    logic [31:0] bus_rdata;
    logic upper_limit_flag;
    logic delta_error_flag;
    int n_errors = 0;
    int num_checks = 0;
    // Mean of the last complete block, expected to hold in between
    logic [31:0] prev_mean = 32'h0000_0000;

    // Result stream partner
    adc_result_src src (.core_clk(core_clk), .sample_out(sample_in));

    adc_result_check_and_stats uut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sample_in(sample_in),
        .bus_req(bus_req),
        .bus_rdata(bus_rdata),
        .upper_limit_flag(upper_limit_flag),
        .delta_error_flag(delta_error_flag)
    );

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // Four-state compare, counted
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic bus_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: d};
    endtask

    // One-cycle read strobe; data is looked at in the following cycle only
    task automatic bus_rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: a, wdata: 32'h0000_0000};
        #1;
        chk(bus_rdata, exp);
    endtask

    // Flag pins, once the taking edge has landed
    task automatic flags(input logic up, input logic dl);
        #1;
        chk({30'h0000_0000, delta_error_flag, upper_limit_flag}, {30'h0000_0000, dl, up});
    endtask

    // Reset values, masking of unused bits, read-only places, unmapped place
    task automatic t_regs();
        logic [15:0] regs [7] = '{16'h20b0, 16'h20b4, 16'h20b8, 16'h21c0, 16'h21c4,
            16'h21c8, 16'h21d0};
        foreach (regs[i]) bus_rd(regs[i], 32'h0000_0000);
        flags(1'b0, 1'b0);
        bus_rd(16'h20bc, 32'h0000_0000);
        bus_wr(adc_stats_pkg::ADDR_UPPER_THR, 32'hffff_1234);
        bus_rd(adc_stats_pkg::ADDR_UPPER_THR, 32'h0000_1234);
        bus_wr(adc_stats_pkg::ADDR_CTRL, 32'hffff_fffe);
        bus_rd(adc_stats_pkg::ADDR_CTRL, 32'h0000_0ffe);
        bus_wr(adc_stats_pkg::ADDR_CTRL, 32'h0000_0000);
        bus_wr(adc_stats_pkg::ADDR_MEAN, 32'h0000_5555);
        bus_rd(adc_stats_pkg::ADDR_MEAN, 32'h0000_0000);
        bus_wr(adc_stats_pkg::ADDR_VAR, 32'h7fff_5555);
        bus_rd(adc_stats_pkg::ADDR_VAR, 32'h0000_0000);
        // Read data must not linger past its single cycle
        @(posedge core_clk);
        #1;
        chk(bus_rdata, 32'h0000_0000);
    endtask

    // Threshold boundary, hold inside the hysteresis band, release below it
    task automatic t_upper();
        bus_wr(adc_stats_pkg::ADDR_UPPER_THR, 32'h0000_1000);
        bus_wr(adc_stats_pkg::ADDR_UPPER_HYST, 32'h0000_0100);
        src.send(16'h1000, 0);
        flags(1'b0, 1'b0);
        src.send(16'h1001, 0);
        flags(1'b1, 1'b1);
        src.send(16'h0f00, 0);
        flags(1'b1, 1'b1);
        bus_rd(adc_stats_pkg::ADDR_FLAGS, 32'h0000_0003);
        src.send(16'h0eff, 0);
        flags(1'b0, 1'b1);
        src.send(16'h1001, 0);
        bus_wr(adc_stats_pkg::ADDR_FLAGS, 32'h0000_0001);
        flags(1'b0, 1'b1);
        src.send(16'h0eff, 0);
    endtask

    // Difference at the limit upward, then just over it in both directions
    task automatic t_delta();
        bus_wr(adc_stats_pkg::ADDR_DELTA, 32'h0000_0010);
        bus_wr(adc_stats_pkg::ADDR_FLAGS, 32'h0000_0002);
        flags(1'b0, 1'b0);
        src.send(16'h0f0f, 0);
        flags(1'b0, 1'b0);
        src.send(16'h0f20, 0);
        flags(1'b0, 1'b1);
        bus_wr(adc_stats_pkg::ADDR_FLAGS, 32'h0000_0002);
        src.send(16'h0f0f, 0);
        flags(1'b0, 1'b1);
        bus_wr(adc_stats_pkg::ADDR_FLAGS, 32'h0000_0002);
    endtask

    // One full block with the given length code; outputs hold until its last result
    task automatic t_stats(input logic [2:0] code);
        int lg;
        int n;
        longint s;
        longint sq;
        logic [15:0] x;
        lg = (code > 3'h4) ? 3 : 7 - int'(code);
        n = 1 << lg;
        s = 0;
        sq = 0;
        bus_wr(adc_stats_pkg::ADDR_CTRL, 32'h0000_0000);
        bus_wr(adc_stats_pkg::ADDR_CTRL, {25'h000_0000, code, 4'h1});
        for (int i = 0; i < n; i++) begin
            x = (i % 2 == 1) ? 16'hffff : 16'(i * 613 + int'(code));
            s += x;
            sq += longint'(x) * x;
            if (i == n - 1) bus_rd(adc_stats_pkg::ADDR_MEAN, prev_mean);
            src.send(x, 0);
        end
        prev_mean = 32'(s >> lg);
        bus_rd(adc_stats_pkg::ADDR_MEAN, prev_mean);
        bus_rd(adc_stats_pkg::ADDR_VAR, 32'((n * sq - s * s) >> (2 * lg)));
    endtask

    // Disabled holds outputs; a partial block is dropped on disable
    task automatic t_hold();
        bus_wr(adc_stats_pkg::ADDR_CTRL, 32'h0000_0040);
        repeat (8) src.send(16'h0123, 0);
        bus_rd(adc_stats_pkg::ADDR_MEAN, prev_mean);
        bus_wr(adc_stats_pkg::ADDR_CTRL, 32'h0000_0041);
        repeat (4) src.send(16'hffff, 0);
        bus_wr(adc_stats_pkg::ADDR_CTRL, 32'h0000_0040);
        bus_wr(adc_stats_pkg::ADDR_CTRL, 32'h0000_0041);
        repeat (8) src.send(16'h0100, 0);
        bus_rd(adc_stats_pkg::ADDR_MEAN, 32'h0000_0100);
        bus_rd(adc_stats_pkg::ADDR_VAR, 32'h0000_0000);
    endtask

    // Counts, then the verdict, then the end of the run
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_b <= 1'b0;
        bus_req <= '{wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 32'h0000_0000};
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_upper();
        t_delta();
        t_stats(3'h0);
        t_stats(3'h1);
        t_stats(3'h2);
        t_stats(3'h3);
        t_stats(3'h4);
        t_stats(3'h7);
        t_hold();
        final_report();
    end

    // Hang guard, far beyond the length of the main sequence
    initial begin
        repeat (50000) @(posedge core_clk);
        n_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0000_0001, 32'h0000_0000);
        final_report();
    end
endmodule
